// ### design/sbp_pkg.sv
`default_nettype none
package sbp_pkg;
  // ----------------------------------------------------------------
  // Link command codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SBP_NOP, SBP_ACT, SBP_RD, SBP_WR, SBP_MWR, SBP_PRE, SBP_MRW
  } sbp_cmd_t;

  // ----------------------------------------------------------------
  // Mode field selectors carried on the bank lines of a mode write
  // ----------------------------------------------------------------
  localparam logic [2:0] SBP_MF_IO_CONFIG = 3'h0;
  localparam logic [2:0] SBP_MF_MASK_CTRL = 3'h1;
  localparam logic [2:0] SBP_MF_BURST = 3'h2;
  localparam int SBP_OP_WBI_BIT = 7;
  localparam int SBP_OP_MASK_DIS_BIT = 5;
  localparam int SBP_OP_BL32_BIT = 0;
  localparam logic SBP_RST_MASK_DIS = 1'h0;
  localparam logic SBP_RST_WBI = 1'h0;
  localparam logic SBP_RST_BL32 = 1'h0;

  // ----------------------------------------------------------------
  // Timing in link clock cycles (nCK)
  // ----------------------------------------------------------------
  localparam int SBP_CNT_W = 8;
  localparam logic [7:0] SBP_T_RCD = 8'h14;
  localparam logic [7:0] SBP_T_RAS = 8'h2D;
  localparam logic [7:0] SBP_T_RPPB = 8'h12;
  localparam logic [7:0] SBP_T_RPAB = 8'h15;
  localparam logic [7:0] SBP_T_RC = 8'h3F;
  localparam logic [7:0] SBP_N_RTP = 8'h08;
  localparam logic [7:0] SBP_T_WR = 8'h14;
  localparam logic [7:0] SBP_WL = 8'h06;
  localparam logic [7:0] SBP_BL16_HALF = 8'h08;
  localparam logic [7:0] SBP_BL32_HALF = 8'h10;
  localparam logic [7:0] SBP_BL32_EXTRA = 8'h08;

  // ----------------------------------------------------------------
  // Controller registers and link clock divider
  // ----------------------------------------------------------------
  localparam logic [7:0] SBP_REG_CMD = 8'h00;
  localparam logic [7:0] SBP_REG_STAT = 8'h04;
  localparam logic [7:0] SBP_REG_MODE = 8'h08;
  localparam int SBP_CK_HALF = 6;
endpackage
`default_nettype wire

// ### design/sbp_link_if.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------------
// Command/address link between controller and memory
// ------------------------------------------------------------------
interface sbp_link_if;
  logic ck;
  logic cs;
  logic [2:0] cmd;
  logic [2:0] ba;
  logic flag;
  logic [7:0] op;
  modport ctrl (output ck, output cs, output cmd, output ba, output flag,
    output op);
  modport dev (input ck, input cs, input cmd, input ba, input flag,
    input op);
endinterface
`default_nettype wire

// ### design/sbp_bank.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------------
// One bank: open state, RAS lockout and auto-close scheduling
// ------------------------------------------------------------------
module sbp_bank (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic do_act,
  input wire logic do_pre,
  input wire logic do_pre_all,
  input wire logic do_col,
  input wire logic col_ap,
  input wire logic col_rd,
  input wire logic bl32,
  output logic open_ff,
  output logic ready_ff,
  output logic act_bad
);
  logic [7:0] ras_ff;
  logic [7:0] ap_cnt_ff;
  logic ap_pend_ff;
  logic [7:0] rec_ff;
  logic [7:0] rd_delay;
  logic [7:0] wr_delay;
  logic [7:0] half;
  logic ap_fire;
  logic close_now;
  logic [7:0] rp_len;

  // Auto-close delays for read and write
  assign half = bl32 ? sbp_pkg::SBP_BL32_HALF : sbp_pkg::SBP_BL16_HALF;
  assign rd_delay = bl32 ? 8'(sbp_pkg::SBP_BL32_EXTRA + sbp_pkg::SBP_N_RTP)
                         : sbp_pkg::SBP_N_RTP;
  // Burst ends on a prefetch boundary, write recovery starts there
  assign wr_delay = 8'(sbp_pkg::SBP_WL + half + 8'h01
                       + sbp_pkg::SBP_T_WR);
  // Internal close waits for both delay and RAS lockout
  assign ap_fire = ap_pend_ff && ap_cnt_ff <= 8'h01
                   && ras_ff <= 8'h01;
  assign close_now = (do_pre || do_pre_all) && open_ff;
  assign rp_len = do_pre_all ? sbp_pkg::SBP_T_RPAB : sbp_pkg::SBP_T_RPPB;
  assign act_bad = do_act && (open_ff || rec_ff > 8'h01);

  // Bank state and its counters advance on rising link clock edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      open_ff <= 1'b0;
      ready_ff <= 1'b1;
      ras_ff <= 8'h00;
      ap_cnt_ff <= 8'h00;
      ap_pend_ff <= 1'b0;
      rec_ff <= 8'h00;
    end else if (tick) begin
      ras_ff <= (ras_ff != 8'h00) ? ras_ff - 8'h01 : 8'h00;
      ap_cnt_ff <= (ap_cnt_ff != 8'h00) ? ap_cnt_ff - 8'h01 : 8'h00;
      rec_ff <= (rec_ff != 8'h00) ? rec_ff - 8'h01 : 8'h00;
      ready_ff <= !open_ff && rec_ff <= 8'h01;
      if (do_act && !act_bad) begin
        open_ff <= 1'b1;
        ready_ff <= 1'b0;
        ras_ff <= sbp_pkg::SBP_T_RAS;
      end else if (close_now) begin
        open_ff <= 1'b0;
        ap_pend_ff <= 1'b0;
        rec_ff <= rp_len;
      end else if (ap_fire) begin
        open_ff <= 1'b0;
        ap_pend_ff <= 1'b0;
        rec_ff <= sbp_pkg::SBP_T_RPPB;
      end else if (do_col && col_ap && open_ff) begin
        ap_pend_ff <= 1'b1;
        ap_cnt_ff <= col_rd ? rd_delay : wr_delay;
      end
    end
  end
endmodule // sbp_bank
`default_nettype wire

// ### design/sbp_dev.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------------
// Memory end: decodes link commands, eight bank units
// ------------------------------------------------------------------
module sbp_dev (
  input wire logic pclk,
  input wire logic presetn,
  sbp_link_if.dev link,
  output logic [7:0] bank_open,
  output logic [7:0] bank_ready,
  output logic illegal_ff,
  output logic mask_on_ff,
  output logic wbi_on_ff,
  output logic bl32_ff
);
  logic [16:0] s1_ff;
  logic [16:0] s2_ff;
  logic ck_prev_ff;
  logic mask_dis_ff;
  logic tick;
  logic cs;
  logic [2:0] cmd;
  logic [2:0] ba;
  logic flag;
  logic [7:0] op;
  logic [7:0] sel;
  logic [7:0] act_bad;
  logic is_col;
  logic col_bad;

  // Link pins sampled twice before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff <= 17'h00000;
      s2_ff <= 17'h00000;
      ck_prev_ff <= 1'b0;
    end else begin
      s1_ff <= {link.ck, link.cs, link.cmd, link.ba, link.flag, link.op};
      s2_ff <= s1_ff;
      ck_prev_ff <= s2_ff[16];
    end
  end

  // Field decode on the rising link edge
  assign tick = s2_ff[16] && !ck_prev_ff;
  assign cs = s2_ff[15] && tick;
  assign cmd = s2_ff[14:12];
  assign ba = s2_ff[11:9];
  assign flag = s2_ff[8];
  assign op = s2_ff[7:0];
  assign sel = 8'h01 << ba;
  assign is_col = cmd == sbp_pkg::SBP_RD || cmd == sbp_pkg::SBP_WR
                  || cmd == sbp_pkg::SBP_MWR;
  assign col_bad = cs && cmd == sbp_pkg::SBP_MWR && mask_dis_ff;

  // Bank units, each timed on its own
  for (genvar b = 0; b < 8; b++) begin : g_bank
    sbp_bank u_bank (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick),
      .do_act(cs && cmd == sbp_pkg::SBP_ACT && sel[b]),
      .do_pre(cs && cmd == sbp_pkg::SBP_PRE && !flag && sel[b]),
      .do_pre_all(cs && cmd == sbp_pkg::SBP_PRE && flag),
      .do_col(cs && is_col && !col_bad && sel[b]),
      .col_ap(flag),
      .col_rd(cmd == sbp_pkg::SBP_RD),
      .bl32(bl32_ff),
      .open_ff(bank_open[b]),
      .ready_ff(bank_ready[b]),
      .act_bad(act_bad[b])
    );
  end

  // Mode fields and illegal command flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_dis_ff <= sbp_pkg::SBP_RST_MASK_DIS;
      mask_on_ff <= !sbp_pkg::SBP_RST_MASK_DIS;
      wbi_on_ff <= sbp_pkg::SBP_RST_WBI;
      bl32_ff <= sbp_pkg::SBP_RST_BL32;
      illegal_ff <= 1'b0;
    end else begin
      illegal_ff <= col_bad || (act_bad != 8'h00);
      if (cs && cmd == sbp_pkg::SBP_MRW) begin
        if (ba == sbp_pkg::SBP_MF_MASK_CTRL) begin
          mask_dis_ff <= op[sbp_pkg::SBP_OP_MASK_DIS_BIT];
          mask_on_ff <= !op[sbp_pkg::SBP_OP_MASK_DIS_BIT];
        end
        if (ba == sbp_pkg::SBP_MF_IO_CONFIG) begin
          wbi_on_ff <= op[sbp_pkg::SBP_OP_WBI_BIT];
        end
        if (ba == sbp_pkg::SBP_MF_BURST) begin
          bl32_ff <= op[sbp_pkg::SBP_OP_BL32_BIT];
        end
      end
    end
  end
endmodule // sbp_dev
`default_nettype wire

// ### design/sbp_ctrl.sv
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Precharge closes one bank or all
// - All-bank flag chooses all; else bank bits
// - No row access before per/all recovery
// - All-bank recovery longer than per-bank
// - Precharge after read: BL/2 and tRAS
// - Activate only after tRP from precharge
// - tRTP counted from BL/2-8 after read
// - Write recovery before precharge after write
// - Internal write starts at prefetch boundary
// - Write to precharge: WL+BL/2+1+tWR
// - Auto-close low keeps bank open
// - Auto-close high closes bank after burst
// - Read auto-close delay nRTP, +8 at BL32
// - Activate after auto-close needs tRP, tRC
// - Write auto-close starts tWR after burst
// - Auto-close allowed after tRCD; tRAS honoured
// - Write then read auto-close covers tWR
// - Mode bits enable masking and inversion
// - Masked write illegal while masking off
// - No column command after read auto-close
// ------------------------------------------------------------------
// Controller end: APB orders, command spacing, link clock divider
// ------------------------------------------------------------------
module sbp_ctrl #(
  parameter int CK_HALF = sbp_pkg::SBP_CK_HALF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready_ff,
  output logic pslverr_ff,
  output logic [31:0] prdata_ff,
  sbp_link_if.ctrl link
);
  logic [7:0] div_ff, op_ff, open_ff;
  logic ck_ff, cs_ff, flag_ff, pend_ff, err_ff, mask_dis_ff, bl32_ff;
  logic [2:0] cmd_ff, ba_ff;
  logic [23:0] order_ff;
  logic [7:0] act_w_ff [8];
  logic [7:0] pre_w_ff [8];
  logic [7:0] col_w_ff [8];
  logic toggle, rise, slot, access, wr_cmd, wr_stat, wr_mode, take, hit;
  logic [2:0] o_cmd, o_ba;
  logic o_flag, b_open, all_pre_ok, legal, time_ok, issue, drop;
  logic [7:0] o_op, b_pre, half, rtp, wrec;

  // Saturating maximum used by the spacing updates of column and precharge orders
  function automatic logic [7:0] sat_max(input logic [7:0] a,
                                         input logic [7:0] b);
    sat_max = (a > b) ? a : b;
  endfunction

  // Link clock divider; commands change on falling edges
  assign toggle = div_ff == 8'(CK_HALF - 1);
  assign rise = toggle && !ck_ff;
  assign slot = toggle && ck_ff;

  // APB decode
  assign access = psel && penable && !pready_ff;
  assign hit = paddr == sbp_pkg::SBP_REG_CMD || paddr == sbp_pkg::SBP_REG_STAT
               || paddr == sbp_pkg::SBP_REG_MODE;
  assign wr_cmd = access && pwrite && paddr == sbp_pkg::SBP_REG_CMD;
  assign wr_mode = access && pwrite && paddr == sbp_pkg::SBP_REG_MODE;
  assign wr_stat = access && pwrite && paddr == sbp_pkg::SBP_REG_STAT;
  // An order waits in the access phase while one is still pending
  assign take = access && (!(wr_cmd || wr_mode) || !pend_ff);

  // Pending order fields
  assign o_cmd = order_ff[2:0];
  assign o_ba = order_ff[6:4];
  assign o_flag = order_ff[8];
  assign o_op = order_ff[23:16];
  assign b_open = open_ff[o_ba];
  assign b_pre = pre_w_ff[o_ba];

  // Burst dependent spacings
  assign half = bl32_ff ? sbp_pkg::SBP_BL32_HALF : sbp_pkg::SBP_BL16_HALF;
  // Counted from BL/2-8 after the read: zero offset at BL16, 8 at BL32
  assign rtp = bl32_ff ? 8'(sbp_pkg::SBP_BL32_EXTRA + sbp_pkg::SBP_N_RTP)
                       : sbp_pkg::SBP_N_RTP;
  assign wrec = 8'(sbp_pkg::SBP_WL + half + 8'h01
                   + sbp_pkg::SBP_T_WR);
  assign all_pre_ok = pre_w_ff[0] == 8'h00 && pre_w_ff[1] == 8'h00
                      && pre_w_ff[2] == 8'h00 && pre_w_ff[3] == 8'h00
                      && pre_w_ff[4] == 8'h00 && pre_w_ff[5] == 8'h00
                      && pre_w_ff[6] == 8'h00 && pre_w_ff[7] == 8'h00;

  // Legality and timing of the pending order
  always_comb begin
    legal = 1'b1;
    time_ok = 1'b1;
    case (sbp_pkg::sbp_cmd_t'(o_cmd))
      sbp_pkg::SBP_ACT: begin
        legal = !b_open;
        time_ok = act_w_ff[o_ba] == 8'h00;
      end
      sbp_pkg::SBP_RD, sbp_pkg::SBP_WR: begin
        legal = b_open;
        time_ok = col_w_ff[o_ba] == 8'h00;
        if (o_cmd == 3'(sbp_pkg::SBP_RD) && o_flag) begin
          time_ok = time_ok && b_pre <= rtp;
        end
      end
      sbp_pkg::SBP_MWR: begin
        legal = b_open && !mask_dis_ff;
        time_ok = col_w_ff[o_ba] == 8'h00;
      end
      sbp_pkg::SBP_PRE: begin
        time_ok = o_flag ? all_pre_ok : b_pre == 8'h00;
      end
      sbp_pkg::SBP_MRW: begin
        time_ok = open_ff == 8'h00;
      end
      default: begin
        legal = 1'b0;
      end
    endcase
  end
  assign issue = slot && pend_ff && legal && time_ok;
  assign drop = slot && pend_ff && !legal;

  // Divider and link pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff <= 8'h00;
      ck_ff <= 1'b0;
      cs_ff <= 1'b0;
      cmd_ff <= 3'h0;
      ba_ff <= 3'h0;
      flag_ff <= 1'b0;
      op_ff <= 8'h00;
    end else begin
      div_ff <= toggle ? 8'h00 : div_ff + 8'h01;
      ck_ff <= toggle ? !ck_ff : ck_ff;
      if (slot) begin
        cs_ff <= issue;
        cmd_ff <= issue ? o_cmd : 3'(sbp_pkg::SBP_NOP);
        ba_ff <= o_ba;
        flag_ff <= o_flag;
        op_ff <= o_op;
      end
    end
  end
  assign link.ck = ck_ff;
  assign link.cs = cs_ff;
  assign link.cmd = cmd_ff;
  assign link.ba = ba_ff;
  assign link.flag = flag_ff;
  assign link.op = op_ff;

  // APB slave: order slot, status and answers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
      pend_ff <= 1'b0;
      order_ff <= 24'h000000;
      err_ff <= 1'b0;
    end else begin
      pready_ff <= take;
      pslverr_ff <= take && !hit;
      if (take && !pwrite) begin
        prdata_ff <= (paddr == sbp_pkg::SBP_REG_CMD) ? {8'h00, order_ff}
          : (paddr == sbp_pkg::SBP_REG_STAT)
            ? {16'h0000, open_ff, 6'h00, err_ff, pend_ff}
          : (paddr == sbp_pkg::SBP_REG_MODE)
            ? {30'h00000000, mask_dis_ff, bl32_ff} // Bit 2 reads zero
          : 32'h00000000;
      end
      if (take && (wr_cmd || wr_mode)) begin
        pend_ff <= 1'b1;
        order_ff <= wr_cmd ? pwdata[23:0]
          : {pwdata[7:0], 8'h00, 1'b0, pwdata[10:8],
             1'b0, 3'(sbp_pkg::SBP_MRW)};
      end else if (issue || drop) begin
        pend_ff <= 1'b0;
      end
      // A refused order sets the error; setting wins over clearing
      if (drop) begin
        err_ff <= 1'b1;
      end else if (take && wr_stat && pwdata[1]) begin
        err_ff <= 1'b0;
      end
    end
  end

  // Bank state mirror and per-bank spacing counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      open_ff <= 8'h00;
      mask_dis_ff <= sbp_pkg::SBP_RST_MASK_DIS;
      bl32_ff <= sbp_pkg::SBP_RST_BL32;
      for (int b = 0; b < 8; b++) begin
        act_w_ff[b] <= 8'h00;
        pre_w_ff[b] <= 8'h00;
        col_w_ff[b] <= 8'h00;
      end
    end else begin
      for (int b = 0; b < 8; b++) begin
        if (rise) begin
          act_w_ff[b] <= (act_w_ff[b] != 8'h00) ? act_w_ff[b] - 8'h01 : 8'h00;
          pre_w_ff[b] <= (pre_w_ff[b] != 8'h00) ? pre_w_ff[b] - 8'h01 : 8'h00;
          col_w_ff[b] <= (col_w_ff[b] != 8'h00) ? col_w_ff[b] - 8'h01 : 8'h00;
        end
        if (issue && o_cmd == 3'(sbp_pkg::SBP_PRE) && o_flag) begin
          open_ff[b] <= 1'b0;
          act_w_ff[b] <= sat_max(act_w_ff[b], sbp_pkg::SBP_T_RPAB);
        end
      end
      if (issue) begin
        case (sbp_pkg::sbp_cmd_t'(o_cmd))
          sbp_pkg::SBP_ACT: begin
            open_ff[o_ba] <= 1'b1;
            col_w_ff[o_ba] <= sbp_pkg::SBP_T_RCD;
            pre_w_ff[o_ba] <= sbp_pkg::SBP_T_RAS;
            act_w_ff[o_ba] <= sbp_pkg::SBP_T_RC;
          end
          sbp_pkg::SBP_RD: begin
            pre_w_ff[o_ba] <= sat_max(b_pre, rtp);
            if (o_flag) begin
              open_ff[o_ba] <= 1'b0;
              act_w_ff[o_ba] <= sat_max(act_w_ff[o_ba],
                8'(sat_max(b_pre, rtp) + sbp_pkg::SBP_T_RPPB));
            end
          end
          sbp_pkg::SBP_WR, sbp_pkg::SBP_MWR: begin
            pre_w_ff[o_ba] <= sat_max(b_pre, wrec);
            if (o_flag) begin
              open_ff[o_ba] <= 1'b0;
              act_w_ff[o_ba] <= sat_max(act_w_ff[o_ba],
                8'(sat_max(b_pre, wrec) + sbp_pkg::SBP_T_RPPB));
            end
          end
          sbp_pkg::SBP_PRE: begin
            if (!o_flag) begin
              open_ff[o_ba] <= 1'b0;
              act_w_ff[o_ba] <= sat_max(act_w_ff[o_ba],
                sbp_pkg::SBP_T_RPPB);
            end
          end
          sbp_pkg::SBP_MRW: begin
            if (o_ba == sbp_pkg::SBP_MF_MASK_CTRL) begin
              mask_dis_ff <= o_op[sbp_pkg::SBP_OP_MASK_DIS_BIT];
            end
            if (o_ba == sbp_pkg::SBP_MF_BURST) begin
              bl32_ff <= o_op[sbp_pkg::SBP_OP_BL32_BIT];
            end
          end
          default: begin
          end
        endcase
      end
    end
  end
endmodule // sbp_ctrl
`default_nettype wire

// ### tb/sbp_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------------
// Link and bank checker beside the controller-to-memory link
// ------------------------------------------------------------------
module sbp_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ck,
  input wire logic cs,
  input wire logic [2:0] cmd,
  input wire logic [2:0] ba,
  input wire logic flag,
  input wire logic [7:0] op,
  input wire logic [7:0] bank_open,
  input wire logic illegal_ff,
  input wire logic mask_on_ff
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic ck_q_ff;
  logic apv_ff;
  logic [2:0] apb_ff;
  logic [11:0] apc_ff;
  // Command taken at the first pclk that sees the link clock high
  wire take = cs & ck & ~ck_q_ff;
  wire is_col = (cmd == sbp_pkg::SBP_RD) | (cmd == sbp_pkg::SBP_WR) |
    (cmd == sbp_pkg::SBP_MWR);
  wire col_ap = take & flag & is_col;
  // Age of a pending auto-close, dropped once its bank has closed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ck_q_ff <= 1'b0;
      apv_ff <= 1'b0;
      apb_ff <= 3'h0;
      apc_ff <= 12'h000;
    end else begin
      ck_q_ff <= ck;
      if (col_ap) begin
        apv_ff <= 1'b1;
        apb_ff <= ba;
        apc_ff <= 12'h000;
      end else if (apv_ff) begin
        apc_ff <= apc_ff + 12'h001;
        if (apc_ff > 12'h004 && !bank_open[apb_ff]) apv_ff <= 1'b0;
      end
    end
  end
  AST_CK_HALF: assert property ($rose(ck) |-> ck[*6] ##1 !ck)
    else $error("link clock high phase not six cycles");
  AST_CMD_HOLD: assert property (ck && $past(ck) |->
    $stable({cs, cmd, ba, flag, op}))
    else $error("command lines moved while link clock high");
  AST_PRE_ONE: assert property (take && cmd == sbp_pkg::SBP_PRE && !flag
    |-> ##[1:5] !bank_open[ba])
    else $error("selected bank not closed by precharge");
  AST_PRE_ALL: assert property (take && cmd == sbp_pkg::SBP_PRE && flag
    |-> ##[1:5] bank_open == 8'h00)
    else $error("all-bank precharge left a bank open");
  AST_ACT_OPEN: assert property (take && cmd == sbp_pkg::SBP_ACT
    |-> ##[1:5] bank_open[ba])
    else $error("activate did not open its bank");
  AST_NOAP_OPEN: assert property (take && !flag && is_col
    |-> ##5 bank_open[ba])
    else $error("bank closed after plain column command");
  AST_NO_ILLEGAL: assert property (!illegal_ff)
    else $error("memory flagged an illegal command");
  AST_MWR_MASK: assert property (take && cmd == sbp_pkg::SBP_MWR
    |-> mask_on_ff)
    else $error("masked write sent while masking off");
  AST_AP_HOLD: assert property (apv_ff && apc_ff < 12'h05A
    |-> bank_open[apb_ff])
    else $error("auto-close came too early");
  AST_AP_DONE: assert property (apv_ff |-> apc_ff < 12'h320)
    else $error("auto-close never closed the bank");
  // Main scenarios reached
  cover property (take && cmd == sbp_pkg::SBP_PRE && flag);
  cover property (col_ap && cmd == sbp_pkg::SBP_RD);
  cover property (take && cmd == sbp_pkg::SBP_MWR);
endmodule // sbp_asserts
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int TMO = 4000;
  logic pclk, presetn, psel, penable, pwrite, pready_ff, pslverr_ff;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata_ff, rdat;
  logic [7:0] bank_open, bank_ready;
  logic illegal_ff, mask_on_ff, wbi_on_ff, bl32_ff, err;
  int bad_count, samples_checked;
  sbp_link_if link_if ();
  sbp_ctrl u_sbp_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready_ff(pready_ff), .pslverr_ff(pslverr_ff), .prdata_ff(prdata_ff),
    .link(link_if));
  sbp_dev u_sbp_dev (.pclk(pclk), .presetn(presetn), .link(link_if),
    .bank_open(bank_open), .bank_ready(bank_ready), .illegal_ff(illegal_ff),
    .mask_on_ff(mask_on_ff), .wbi_on_ff(wbi_on_ff), .bl32_ff(bl32_ff));
  sbp_asserts u_sbp_asserts (.pclk(pclk), .presetn(presetn),
    .ck(link_if.ck), .cs(link_if.cs), .cmd(link_if.cmd), .ba(link_if.ba),
    .flag(link_if.flag), .op(link_if.op), .bank_open(bank_open),
    .illegal_ff(illegal_ff), .mask_on_ff(mask_on_ff));
  // Clock
  always #2 pclk = ~pclk;
  // ----------------------------------------------------------------
  // Report, bus and compare tasks
  // ----------------------------------------------------------------
  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t register got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t pin got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready_ff !== 1'b1 && n < TMO);
    if (n >= TMO) begin
      bad_count++;
      $display("[FAIL] %0t bus answer missing", $time);
      print_verdict();
    end
    rdat = prdata_ff;
    err = pslverr_ff;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Poll until the queued order has gone out, then let the memory act
  task automatic idle;
    int n;
    n = 0;
    do begin
      xfer(1'b0, sbp_pkg::SBP_REG_STAT, 32'h0);
      n++;
    end while (rdat[0] !== 1'b0 && n < TMO);
    if (n >= TMO) begin
      bad_count++;
      $display("[FAIL] %0t order never left the controller", $time);
      print_verdict();
    end
    repeat (24) @(posedge pclk);
  endtask
  task automatic order(input logic [2:0] c, input logic [2:0] b,
                       input logic f);
    xfer(1'b1, sbp_pkg::SBP_REG_CMD, {23'h000000, f, 1'b0, b, 1'b0, c});
    idle();
  endtask
  task automatic mode(input logic [2:0] fld, input logic [7:0] v);
    xfer(1'b1, sbp_pkg::SBP_REG_MODE, {21'h000000, fld, v});
    idle();
  endtask
  task automatic wait_closed(input int b);
    int n;
    n = 0;
    while (bank_open[b] !== 1'b0 && n < TMO) begin
      @(posedge pclk);
      n++;
    end
    if (n >= TMO) begin
      bad_count++;
      $display("[FAIL] %0t bank never closed", $time);
      print_verdict();
    end
  endtask
  // Read the error flag, then clear it
  task automatic err_flag(input logic exp);
    xfer(1'b0, sbp_pkg::SBP_REG_STAT, 32'h0);
    chk({31'h0, rdat[1]}, {31'h0, exp});
    xfer(1'b1, sbp_pkg::SBP_REG_STAT, 32'h00000002);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    bad_count = 0;
    samples_checked = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    chk_pin(bank_open, 8'h00);
    chk_pin(bank_ready, 8'hFF);
    chk_pin({6'h00, mask_on_ff, wbi_on_ff}, 8'h02);
    xfer(1'b0, 8'h40, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rdat, 32'h0);
    // Open every bank, then close them one at a time
    for (int b = 0; b < 8; b++) order(sbp_pkg::SBP_ACT, b[2:0], 1'b0);
    chk_pin(bank_open, 8'hFF);
    xfer(1'b0, sbp_pkg::SBP_REG_STAT, 32'h0);
    chk({24'h0, rdat[15:8]}, 32'h000000FF);
    for (int b = 0; b < 8; b++) begin
      order(sbp_pkg::SBP_PRE, b[2:0], 1'b0);
      chk_pin(bank_open, 8'hFE << b);
    end
    // All-bank close ignores bank bits and recovers more slowly
    for (int b = 0; b < 8; b++) order(sbp_pkg::SBP_ACT, b[2:0], 1'b0);
    order(sbp_pkg::SBP_PRE, 3'h5, 1'b1);
    chk_pin(bank_open, 8'h00);
    repeat (216) @(posedge pclk);
    chk_pin(bank_ready, 8'h00);
    repeat (36) @(posedge pclk);
    chk_pin(bank_ready, 8'hFF);
    // Read plain, read with auto-close, then a refused read
    order(sbp_pkg::SBP_ACT, 3'h2, 1'b0);
    order(sbp_pkg::SBP_RD, 3'h2, 1'b0);
    chk_pin({7'h00, bank_open[2]}, 8'h01);
    order(sbp_pkg::SBP_RD, 3'h2, 1'b1);
    chk_pin({7'h00, bank_open[2]}, 8'h01);
    wait_closed(2);
    chk_pin({7'h00, bank_open[2]}, 8'h00);
    order(sbp_pkg::SBP_RD, 3'h2, 1'b0);
    err_flag(1'b1);
    // Write with auto-close and a legal masked write
    order(sbp_pkg::SBP_ACT, 3'h4, 1'b0);
    order(sbp_pkg::SBP_WR, 3'h4, 1'b1);
    chk_pin({7'h00, bank_open[4]}, 8'h01);
    wait_closed(4);
    chk_pin({7'h00, bank_open[4]}, 8'h00);
    order(sbp_pkg::SBP_ACT, 3'h5, 1'b0);
    order(sbp_pkg::SBP_MWR, 3'h5, 1'b0);
    err_flag(1'b0);
    order(sbp_pkg::SBP_PRE, 3'h0, 1'b1);
    // Mode fields: masking off, write inversion on, long burst
    mode(sbp_pkg::SBP_MF_MASK_CTRL, 8'h20);
    chk_pin({7'h00, mask_on_ff}, 8'h00);
    mode(sbp_pkg::SBP_MF_IO_CONFIG, 8'h80);
    chk_pin({7'h00, wbi_on_ff}, 8'h01);
    mode(sbp_pkg::SBP_MF_BURST, 8'h01);
    chk_pin({7'h00, bl32_ff}, 8'h01);
    xfer(1'b0, sbp_pkg::SBP_REG_MODE, 32'h0);
    chk({29'h0, rdat[2:0]}, 32'h00000003);
    order(sbp_pkg::SBP_ACT, 3'h5, 1'b0);
    order(sbp_pkg::SBP_MWR, 3'h5, 1'b0);
    err_flag(1'b1);
    order(sbp_pkg::SBP_RD, 3'h5, 1'b1);
    wait_closed(5);
    chk_pin({7'h00, bank_open[5]}, 8'h00);
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
